// [rtl/cbi_top.sv]
// Caches, write and read buffers and multiplexed bus of the memory path
//
// Behaviour
// - Instruction cache 4kB or 8kB per variant, 16-byte lines of four words.
// - Instruction cache direct mapped over the full 4GB physical range.
// - Instruction cache indexed and tagged physically; no flush on switch.
// - Data cache of 2kB with one-word lines on every variant.
// - Data cache direct mapped, physically addressed, any word cacheable.
// - Data cache write-through: every store goes to main memory.
// - Four-entry write buffer takes stores at core rate, stalling only when full.
// - Write buffer drains in order, one bus write per entry.
// - Address and data share one set of multiplexed bus pins.
// - Address latch strobe marks the address phase for outside latches.
// - Reads and writes complete through a simple handshake from memory.
// - Bus arbiter can hand the external bus to an outside master.
// - Bus supports single-word reads and four-word block reads.
// - Block reads accept per-word handshake or clock-rate streaming.
// - Block words gather in a 4-deep read FIFO before the fill.
// - Block read on every instruction miss; data misses only if strapped.
// - Low word address: word address for singles, counter from 0 for blocks.
// - Page hint on back-to-back writes within one 256-byte page.
`timescale 1ns/10ps
`default_nettype none
module cbi_top import cbi_pkg::*; #(
  parameter bit ICACHE_LARGE = 1'b0
) (
  input  wire logic         CLOCK_I,
  input  wire logic         RST_I,
  input  wire logic         IFETCH_REQ_I,
  input  wire logic [31:0]  IFETCH_ADDR_I,
  output logic              IFETCH_RDY_O,
  output logic      [31:0]  IFETCH_DATA_O,
  input  wire cbi_dreq_type DREQ_I,
  output logic              DRDY_O,
  output logic      [31:0]  DRDATA_O,
  input  wire logic         DBLOCK_REFILL_I,
  input  wire logic [31:0]  AD_I,
  output logic      [31:0]  AD_O,
  output logic              AD_OE_O,
  output logic      [1:0]   ADDR_LO_O,
  output logic              ALE_O,
  output logic              DATA_EN_N_O,
  output logic              BLOCK_REQUEST_OR_PAGE_HINT_N_O,
  output logic              RD_N_O,
  output logic              WR_N_O,
  input  wire logic         ACK_N_I,
  input  wire logic         READ_FIFO_LOAD_STROBE_N_I,
  input  wire logic         BUS_REQ_N_I,
  output logic              BUS_GNT_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and reset-time strap

  logic [35:0] sy1_r;
  logic [35:0] sy2_r;
  logic        ack_s;
  logic        read_fifo_load_strobe_s;
  logic        busreq_s;
  logic        strap_s;
  logic [31:0] ad_s;
  logic [1:0]  init_cnt_r;
  logic        dblock_r;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      sy1_r <= SYNC_RESET;
      sy2_r <= SYNC_RESET;
    end else begin
      sy1_r <= {ACK_N_I, READ_FIFO_LOAD_STROBE_N_I, BUS_REQ_N_I,
                DBLOCK_REFILL_I, AD_I};
      sy2_r <= sy1_r;
    end
  end

  assign ack_s    = !sy2_r[35];
  assign read_fifo_load_strobe_s  = !sy2_r[34];
  assign busreq_s = !sy2_r[33];
  assign strap_s  = sy2_r[32];
  assign ad_s     = sy2_r[31:0];

  // Strap is sampled until the synchroniser has settled, then frozen
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      init_cnt_r <= '0;
      dblock_r   <= 1'b0;
    end else if (init_cnt_r != STRAP_SETTLE) begin
      init_cnt_r <= init_cnt_r + 2'h1;
      dblock_r   <= strap_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache arrays and lookups

  typedef enum {S_IDLE, S_ADDR, S_WDATA, S_RDATA, S_FILL, S_DMA} cbi_st_type;

  logic [31:0]          ic_data [IC_LINES*4];
  logic [IC_TAG_W-1:0]  ic_tag  [IC_LINES];
  logic [IC_LINES-1:0]  ic_valid_r;
  logic [31:0]          dc_data [DC_WORDS];
  logic [DC_TAG_W-1:0]  dc_tag  [DC_WORDS];
  logic [DC_WORDS-1:0]  dc_valid_r;

  logic [IC_IDX_W-1:0]  ic_idx;
  logic [DC_IDX_W-1:0]  dc_idx;
  logic                 ic_hit;
  logic                 dc_hit;
  logic [31:0]          st_merge;
  cbi_st_type           state_r;
  logic                 cur_write_r;
  logic                 cur_block_r;
  logic                 cur_icache_r;
  logic [29:0]          cur_addr_r;
  logic [2:0]           rcnt_r;
  logic [2:0]           fcnt_r;
  logic [2:0]           need;
  logic [29:0]          fill_waddr;
  logic [IC_IDX_W-1:0]  ic_fidx;
  logic                 fill_go;
  logic [31:0]          rb_out;
  logic                 rb_out_valid;
  logic                 rb_in_ready;

  // Small variant forces the top index bit low; full tags keep both correct
  assign ic_idx = {ICACHE_LARGE & IFETCH_ADDR_I[IC_IDX_LSB+IC_IDX_W-1],
                   IFETCH_ADDR_I[IC_IDX_LSB +: IC_IDX_W-1]};
  assign ic_hit = ic_valid_r[ic_idx] &&
                  ic_tag[ic_idx] == IFETCH_ADDR_I[31:IC_IDX_LSB];
  assign dc_idx = DREQ_I.addr[DC_IDX_LSB +: DC_IDX_W];
  assign dc_hit = dc_valid_r[dc_idx] &&
                  dc_tag[dc_idx] == DREQ_I.addr[31:DC_TAG_LSB];

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_merge
      assign st_merge[8*b +: 8] = DREQ_I.be[b] ? DREQ_I.wdata[8*b +: 8]
                                               : dc_data[dc_idx][8*b +: 8];
    end
  endgenerate

  assign need       = cur_block_r ? BURST_WORDS : SINGLE_WORDS;
  assign fill_waddr = cur_block_r ? {cur_addr_r[29:2], fcnt_r[1:0]}
                                  : cur_addr_r;
  assign ic_fidx    = {ICACHE_LARGE & cur_addr_r[IC_IDX_LSB-2+IC_IDX_W-1],
                       cur_addr_r[IC_IDX_LSB-2 +: IC_IDX_W-1]};
  assign fill_go    = (state_r == S_FILL) && rb_out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Core ports

  logic irdy_r;
  logic drdy_r;
  logic ld_req;
  logic st_req;
  logic st_go;
  logic imiss;
  logic dmiss;
  logic wb_in_ready;
  logic wb_out_valid;
  logic wb_pop;
  cbi_wbuf_type wb_in;
  cbi_wbuf_type wb_out;

  assign ld_req = DREQ_I.valid && !DREQ_I.we && !drdy_r;
  assign st_req = DREQ_I.valid && DREQ_I.we && !drdy_r;
  assign st_go  = st_req && wb_in_ready;
  assign imiss  = IFETCH_REQ_I && !irdy_r && !ic_hit;
  // Data misses wait until the block-refill strap has been captured
  assign dmiss  = ld_req && !dc_hit && (init_cnt_r == STRAP_SETTLE);
  assign wb_in  = '{waddr: DREQ_I.addr[31:2], be: DREQ_I.be,
                    data: DREQ_I.wdata};

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      irdy_r        <= 1'b0;
      IFETCH_DATA_O <= '0;
    end else begin
      irdy_r <= IFETCH_REQ_I && !irdy_r && ic_hit;
      if (IFETCH_REQ_I && ic_hit) begin
        IFETCH_DATA_O <= ic_data[{ic_idx, IFETCH_ADDR_I[3:2]}];
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      drdy_r   <= 1'b0;
      DRDATA_O <= '0;
    end else begin
      drdy_r <= (ld_req && dc_hit) || st_go;
      if (ld_req && dc_hit) begin
        DRDATA_O <= dc_data[dc_idx];
      end
    end
  end

  assign IFETCH_RDY_O = irdy_r;
  assign DRDY_O       = drdy_r;

  // Fills write the arrays only once every word of the line has arrived; store hits merge at once unless a data fill writes in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (fill_go && cur_icache_r) begin
      ic_data[{ic_fidx, fcnt_r[1:0]}] <= rb_out;
      ic_tag[ic_fidx]                 <= cur_addr_r[29:2];
    end
    if (fill_go && !cur_icache_r) begin
      dc_data[fill_waddr[DC_IDX_W-1:0]] <= rb_out;
      dc_tag[fill_waddr[DC_IDX_W-1:0]]  <= fill_waddr[29:DC_TAG_LSB-2];
    end else if (st_go && dc_hit) begin
      dc_data[dc_idx] <= st_merge;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ic_valid_r <= '0;
      dc_valid_r <= '0;
    end else if (fill_go) begin
      // Line stays invalid while its words are rewritten, so no early hit
      if (cur_icache_r) begin
        ic_valid_r[ic_fidx] <= (fcnt_r == BURST_WORDS - 3'h1);
      end
      if (!cur_icache_r) begin
        dc_valid_r[fill_waddr[DC_IDX_W-1:0]] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffers

  assign wb_pop = (state_r == S_WDATA) && ack_s;

  cbi_fifo #(.WIDTH(WB_W), .DEPTH(WB_DEPTH)) u_wbuf (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .in_valid_i  (st_go),
    .in_ready_o  (wb_in_ready),
    .in_data_i   (wb_in),
    .out_valid_o (wb_out_valid),
    .out_ready_i (wb_pop),
    .out_data_o  (wb_out)
  );

  cbi_fifo #(.WIDTH(32), .DEPTH(RB_DEPTH)) u_rbuf (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .in_valid_i  ((state_r == S_RDATA) && read_fifo_load_strobe_s),
    .in_ready_o  (rb_in_ready),
    .in_data_i   (ad_s),
    .out_valid_o (rb_out_valid),
    .out_ready_i (state_r == S_FILL),
    .out_data_o  (rb_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer

  logic                 near_r;
  logic                 last_wr_r;
  logic [31-PAGE_LSB:0] last_page_r;
  logic [31:0]          ad_r;

  // Writes go first so a load miss never overtakes a buffered store
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r      <= S_IDLE;
      cur_write_r  <= 1'b0;
      cur_block_r  <= 1'b0;
      cur_icache_r <= 1'b0;
      cur_addr_r   <= '0;
      rcnt_r       <= '0;
      fcnt_r       <= '0;
      near_r       <= 1'b0;
      last_wr_r    <= 1'b0;
      last_page_r  <= '0;
      ad_r         <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          rcnt_r <= '0;
          fcnt_r <= '0;
          if (busreq_s) begin
            state_r   <= S_DMA;
            last_wr_r <= 1'b0;
          end else if (wb_out_valid) begin
            state_r     <= S_ADDR;
            cur_write_r <= 1'b1;
            cur_block_r <= 1'b0;
            cur_addr_r  <= wb_out.waddr;
            near_r      <= last_wr_r &&
                           wb_out.waddr[29:PAGE_LSB-2] == last_page_r;
            ad_r        <= {wb_out.waddr[29:2], ~wb_out.be};
          end else if (dmiss) begin
            state_r      <= S_ADDR;
            cur_write_r  <= 1'b0;
            cur_block_r  <= dblock_r;
            cur_icache_r <= 1'b0;
            cur_addr_r   <= DREQ_I.addr[31:2];
            last_wr_r    <= 1'b0;
            ad_r         <= {DREQ_I.addr[31:4], ALL_BYTES_N};
          end else if (imiss) begin
            state_r      <= S_ADDR;
            cur_write_r  <= 1'b0;
            cur_block_r  <= 1'b1;
            cur_icache_r <= 1'b1;
            cur_addr_r   <= {IFETCH_ADDR_I[31:4], 2'h0};
            last_wr_r    <= 1'b0;
            ad_r         <= {IFETCH_ADDR_I[31:4], ALL_BYTES_N};
          end
        end
        S_ADDR: begin
          if (cur_write_r) begin
            state_r <= S_WDATA;
            ad_r    <= wb_out.data;
          end else begin
            state_r <= S_RDATA;
          end
        end
        S_WDATA: begin
          if (ack_s) begin
            state_r     <= S_IDLE;
            last_wr_r   <= 1'b1;
            last_page_r <= cur_addr_r[29:PAGE_LSB-2];
          end
        end
        S_RDATA: begin
          // One strobe per word, whether paced by handshake or streamed
          if (read_fifo_load_strobe_s && rb_in_ready) begin
            rcnt_r <= rcnt_r + 3'h1;
            if (rcnt_r + 3'h1 == need) begin
              state_r <= S_FILL;
            end
          end
        end
        S_FILL: begin
          if (rb_out_valid) begin
            fcnt_r <= fcnt_r + 3'h1;
            if (fcnt_r + 3'h1 == need) begin
              state_r <= S_IDLE;
            end
          end
        end
        S_DMA: begin
          if (!busreq_s) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  assign ALE_O       = (state_r == S_ADDR);
  assign AD_O        = ad_r;
  assign AD_OE_O     = (state_r == S_ADDR) || (state_r == S_WDATA);
  assign DATA_EN_N_O = (state_r != S_RDATA);
  assign RD_N_O      = !(!cur_write_r &&
                         (state_r == S_ADDR || state_r == S_RDATA));
  assign WR_N_O      = !(cur_write_r &&
                         (state_r == S_ADDR || state_r == S_WDATA));
  assign ADDR_LO_O   = (cur_write_r || !cur_block_r) ? cur_addr_r[1:0]
                                                     : rcnt_r[1:0];
  assign BLOCK_REQUEST_OR_PAGE_HINT_N_O =
    !((!RD_N_O && cur_block_r) || (!WR_N_O && near_r));
  assign BUS_GNT_N_O = (state_r != S_DMA);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  sequence s_write_addr;
    ALE_O && !WR_N_O;
  endsequence
  sequence s_write_data;
    !ALE_O && !WR_N_O && AD_OE_O && AD_O == $past(wb_out.data);
  endsequence

  property p_ale_single;
    ALE_O |=> !ALE_O;
  endproperty
  a_ale_single: assert property (p_ale_single)
    else $error("address strobe held longer than one cycle");

  property p_write_phases;
    s_write_addr |=> s_write_data;
  endproperty
  a_write_phases: assert property (p_write_phases)
    else $error("write data phase did not follow address phase");

  property p_ack_ends_write;
    (state_r == S_WDATA && ack_s) |=> (WR_N_O && !AD_OE_O);
  endproperty
  a_ack_ends_write: assert property (p_ack_ends_write)
    else $error("write not ended by acknowledge");

  property p_stall_full;
    (st_req && !wb_in_ready) |=> !DRDY_O;
  endproperty
  a_stall_full: assert property (p_stall_full)
    else $error("store accepted while write buffer full");

  property p_store_flows;
    (st_req && wb_in_ready) |=> DRDY_O;
  endproperty
  a_store_flows: assert property (p_store_flows)
    else $error("store stalled with write buffer room");

  property p_icache_block;
    (ALE_O && !RD_N_O && cur_icache_r) |-> !BLOCK_REQUEST_OR_PAGE_HINT_N_O;
  endproperty
  a_icache_block: assert property (p_icache_block)
    else $error("instruction miss without block request");

  property p_burst_from_zero;
    (ALE_O && !RD_N_O && cur_block_r) |-> ADDR_LO_O == 2'h0;
  endproperty
  a_burst_from_zero: assert property (p_burst_from_zero)
    else $error("block read word counter not starting at zero");

  property p_fill_after_all;
    $rose(state_r == S_FILL) |-> rcnt_r == need && !$past(fill_go);
  endproperty
  a_fill_after_all: assert property (p_fill_after_all)
    else $error("line fill began before all words arrived");

  property p_dma_grant;
    (state_r == S_IDLE && busreq_s) |=> !BUS_GNT_N_O && !AD_OE_O;
  endproperty
  a_dma_grant: assert property (p_dma_grant)
    else $error("bus not granted to outside master");

endmodule
`default_nettype wire

// [rtl/cbi_pkg.sv]
// Shared constants and carrier types of the cache and bus interface
package cbi_pkg;

  localparam int IC_BYTES_SMALL = 4096;
  localparam int IC_BYTES_LARGE = 8192;
  localparam int LINE_BYTES     = 16;
  localparam int IC_LINES       = IC_BYTES_LARGE / LINE_BYTES;
  localparam int IC_IDX_W       = $clog2(IC_LINES);
  localparam int IC_IDX_LSB     = 4;
  localparam int IC_TAG_W       = 32 - IC_IDX_LSB;

  localparam int DC_BYTES       = 2048;
  localparam int DC_WORDS       = DC_BYTES / 4;
  localparam int DC_IDX_W       = $clog2(DC_WORDS);
  localparam int DC_IDX_LSB     = 2;
  localparam int DC_TAG_LSB     = DC_IDX_LSB + DC_IDX_W;
  localparam int DC_TAG_W       = 32 - DC_TAG_LSB;

  localparam int WB_DEPTH       = 4;
  localparam int RB_DEPTH       = 4;
  localparam int PAGE_LSB       = 8;

  localparam logic [2:0]  BURST_WORDS   = 3'h4;
  localparam logic [2:0]  SINGLE_WORDS  = 3'h1;
  localparam logic [1:0]  STRAP_SETTLE  = 2'h3;
  localparam logic [3:0]  ALL_BYTES_N   = 4'h0;
  // Sync chain order: ack_n, load_strobe_n, bus_req_n, strap, ad[31:0]
  localparam logic [35:0] SYNC_RESET    = 36'hE00000000;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cbi_dreq_type;

  typedef struct packed {
    logic [29:0] waddr;
    logic [3:0]  be;
    logic [31:0] data;
  } cbi_wbuf_type;

  localparam int WB_W = $bits(cbi_wbuf_type);

endpackage

// [rtl/cbi_fifo.sv]
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module cbi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_r != FULL_CNT);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers wrap naturally because DEPTH is a power of two
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_full_holds;
    @(posedge clk_i) disable iff (rst_i)
      (cnt_r == FULL_CNT && !out_ready_i) |=> (cnt_r == FULL_CNT);
  endproperty
  a_full_holds: assert property (p_full_holds)
    else $error("fifo lost an entry while full");

endmodule
`default_nettype wire

// [tb/cbi_mem_model.sv]
// Memory controller and address latch model on the multiplexed bus
`timescale 1ns/10ps
`default_nettype none
module cbi_mem_model (
  input  wire logic        clk_i,
  input  wire logic        ale_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        den_n_i,
  input  wire logic        blk_n_i,
  input  wire logic [1:0]  lo_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [1:0]  gap_i,
  output logic      [31:0] ad_o,
  output logic             ld_n_o,
  output logic             ack_n_o,
  output logic             ev_o,
  output logic             ev_wr_o,
  output logic             ev_blk_o,
  output logic      [3:0]  ev_be_o,
  output logic      [31:0] ev_a_o,
  output logic      [31:0] ev_d_o
);
  logic [31:0] mem [int unsigned];
  logic [31:0] w;
  int          k;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'hA5A50000;
  endfunction
  // Every change lands just after the edge, never on it
  task automatic tk;
    @(posedge clk_i);
    #1;
  endtask
  initial begin
    {ld_n_o, ack_n_o, ev_o} = 3'h6;
    ad_o = 32'h0;
    forever begin
      tk();
      ev_o = 1'b0;
      if (ale_i) begin
        ev_a_o = {ad_i[31:4], lo_i, 2'h0};
        ev_be_o = ad_i[3:0];
        ev_wr_o = !wr_n_i;
        ev_blk_o = !blk_n_i;
        if (ev_wr_o) begin
          repeat (4 * gap_i + 1) tk();
          ev_d_o = ad_i;
          ack_n_o = 1'b0;
          tk();
          ack_n_o = 1'b1;
          w = rd(ev_a_o);
          for (k = 0; k < 4; k++) if (!ev_be_o[k]) w[8*k+:8] = ev_d_o[8*k+:8];
          mem[ev_a_o] = w;
          while (!wr_n_i) tk();
        end else begin
          while (den_n_i) tk();
          for (k = 0; k < (ev_blk_o ? 4 : 1); k++) begin
            repeat (gap_i) tk();
            ad_o = rd(ev_a_o + 32'(4 * k));
            ld_n_o = 1'b0;
            tk();
            // Streamed words keep the strobe low from one word to the next
            if (gap_i != 2'h0 || k == (ev_blk_o ? 3 : 0)) begin
              ld_n_o = 1'b1;
              // Released bus shows a changed pattern, not stale data
              ad_o = ~ad_o;
            end
          end
          while (!rd_n_i) tk();
        end
        ev_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/cbi_top_tb.sv]
// Self-checking bench for the cache and bus interface
`timescale 1ns/10ps
`default_nettype none
module cbi_top_tb import cbi_pkg::*;;
  logic         clk = 1'b0, rst = 1'b1, ifq = 1'b0, strap = 1'b0;
  logic         breq_n = 1'b1, pw = 1'b0, xblk = 1'b0;
  logic [31:0]  ifa = 32'h0, b, db, r, pa, ifd, drd, ado, m_ad, ev_a, ev_d;
  logic [1:0]   gap = 2'h0, lo;
  cbi_dreq_type dq = '0;
  logic [3:0]   ev_be;
  logic         ifr, drdy, oe, ale, den_n, blk_n, rd_n, wr_n, ack_n, ld_n;
  logic         gnt_n, ev, ev_wr, ev_blk;
  logic [31:0]  mem [int unsigned];
  logic [31:0]  ict [int unsigned];
  logic [31:0]  dct [int unsigned];
  logic [67:0]  wq [$];
  int           error_cnt = 0, checks_done = 0, pushed = 0, retired = 0, i, n;

  cbi_top #(.ICACHE_LARGE(1'b0)) cbi_top_i (.CLOCK_I(clk), .RST_I(rst),
    .IFETCH_REQ_I(ifq), .IFETCH_ADDR_I(ifa), .IFETCH_RDY_O(ifr),
    .IFETCH_DATA_O(ifd), .DREQ_I(dq), .DRDY_O(drdy), .DRDATA_O(drd),
    .DBLOCK_REFILL_I(strap), .AD_I(oe ? ado : m_ad), .AD_O(ado),
    .AD_OE_O(oe), .ADDR_LO_O(lo), .ALE_O(ale), .DATA_EN_N_O(den_n),
    .BLOCK_REQUEST_OR_PAGE_HINT_N_O(blk_n), .RD_N_O(rd_n), .WR_N_O(wr_n),
    .ACK_N_I(ack_n), .READ_FIFO_LOAD_STROBE_N_I(ld_n),
    .BUS_REQ_N_I(breq_n), .BUS_GNT_N_O(gnt_n));
  cbi_mem_model cbi_mem_model_i (.clk_i(clk), .ale_i(ale), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .den_n_i(den_n), .blk_n_i(blk_n), .lo_i(lo),
    .ad_i(ado), .gap_i(gap), .ad_o(m_ad), .ld_n_o(ld_n), .ack_n_o(ack_n),
    .ev_o(ev), .ev_wr_o(ev_wr), .ev_blk_o(ev_blk), .ev_be_o(ev_be),
    .ev_a_o(ev_a), .ev_d_o(ev_d));

  initial forever #25 clk = ~clk;
  initial begin
    #(50 * 60000);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'hA5A50000;
  endfunction
  function automatic logic [31:0] msk(input logic [3:0] e);
    for (int j = 0; j < 4; j++) msk[8*j+:8] = {8{e[j]}};
  endfunction
  task automatic chk(input logic [31:0] g, x, input string m);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Each finished bus transfer reported by the memory model
  always @(posedge clk) if (ev === 1'b1) begin
    if (ev_wr) begin
      chk(ev_a, wq[0][63:32], "write addr");
      chk(32'(ev_be ^ wq[0][67:64]), 32'hF, "byte enables");
      chk(ev_d & msk(wq[0][67:64]), wq[0][31:0] & msk(wq[0][67:64]), "wdata");
      chk(32'(ev_blk), 32'(pw && pa[31:8] == ev_a[31:8]), "page hint");
      void'(wq.pop_front());
      retired++;
    end else begin
      chk(32'(ev_blk), 32'(xblk), "block request");
      if (xblk) chk(32'(ev_a[3:2]), 32'h0, "block start");
    end
    pw = ev_wr;
    pa = ev_a;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic fetch(input logic [31:0] a);
    logic h;
    n = 0;
    a[1:0] = 2'h0;
    h = ict.exists(a[11:4]) && ict[a[11:4]] == a[31:4];
    xblk = 1'b1;
    ifa = a;
    ifq = 1'b1;
    do begin @(negedge clk); n++; end while (ifr !== 1'b1 && n < 300);
    ifq = 1'b0;
    chk(ifd, rd(a), "fetch data");
    chk(32'(n == 1), 32'(h), "fetch latency");
    ict[a[11:4]] = a[31:4];
    @(negedge clk);
    chk(32'(ifr), 32'h0, "fetch pulse");
  endtask
  task automatic dacc(input logic w, input logic [3:0] e, input logic [31:0] a, d);
    int oc;
    logic h;
    n = 0;
    // A write popped at the last edge is counted retired only at the next
    oc = pushed - retired - int'(ev === 1'b1 && ev_wr === 1'b1);
    a[1:0] = 2'h0;
    h = dct.exists(a[10:2]) && dct[a[10:2]] == a;
    xblk = strap;
    dq = '{1'b1, w, e, a, d};
    do begin @(negedge clk); n++; end while (drdy !== 1'b1 && n < 400);
    dq.valid = 1'b0;
    if (w) begin
      mem[a] = (rd(a) & ~msk(e)) | (d & msk(e));
      wq.push_back({e, a, d});
      pushed++;
      if (oc <= 3) chk(32'(n), 32'h1, "store accept");
      if (oc >= 4) chk(32'(n > 1), 32'h1, "store stall");
    end else begin
      chk(drd, rd(a), "load data");
      chk(32'(n == 1), 32'(h), "load latency");
      if (strap && !h) for (int j = 0; j < 4; j++) dct[{a[10:4], 2'(j)}] = {a[31:4], 2'(j), 2'h0};
      else dct[a[10:2]] = a;
    end
    @(negedge clk);
    chk(32'(drdy), 32'h0, "data pulse");
  endtask
  task automatic do_reset(input logic s);
    rst = 1'b1;
    strap = s;
    repeat (20) @(negedge clk);
    chk(32'({oe, ale, rd_n, wr_n, den_n, blk_n, gnt_n}), 32'h1F, "idle");
    rst = 1'b0;
    ict.delete();
    dct.delete();
    pw = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic drain;
    n = 0;
    while (pushed != retired && n < 900) begin @(negedge clk); n++; end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(13257));
    do_reset(1'b0);
    b = $urandom & 32'h7FFFFFF0;
    db = $urandom | 32'h80000000;
    db[7:0] = 8'h0;
    fetch(b);
    fetch(b + 4);
    fetch(b + 12);
    fetch(b + 32'h1000);
    fetch(b);
    // Slow acknowledge fills the write buffer
    gap = 2'h3;
    for (i = 0; i < 6; i++) dacc(1'b1, 4'hF, db + 32'(4 * i), $urandom);
    dacc(1'b1, 4'hF, db ^ 32'h100, $urandom);
    gap = 2'h0;
    dacc(1'b0, 4'hF, db, 32'h0);
    dacc(1'b0, 4'hF, db, 32'h0);
    dacc(1'b1, 4'h3, db, $urandom);
    dacc(1'b0, 4'hF, db, 32'h0);
    dacc(1'b0, 4'hF, db + 32'h800, 32'h0);
    drain();
    breq_n = 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (gnt_n !== 1'b0 && n < 50);
    chk(32'({gnt_n, oe, rd_n, wr_n}), 32'h3, "grant");
    breq_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(32'(gnt_n), 32'h1, "regrant");
    do_reset(1'b1);
    dacc(1'b0, 4'hF, db + 8, 32'h0);
    dacc(1'b0, 4'hF, db + 12, 32'h0);
    fetch(b);
    for (i = 0; i < 12; i++) begin
      gap = 2'($urandom);
      r = $urandom;
      if (r[0]) fetch(b + {r[12:4], 4'h0});
      else dacc(r[1], 4'hF, db + {r[12:2], 2'h0}, $urandom);
    end
    drain();
    finish_test();
  end
endmodule
`default_nettype wire
